// ---- common/fsp_pkg.sv ----
// constants, field layouts and state types for the flash self-programming controller
package fsp_pkg;

  // register select on the special function register port
  localparam logic FSP_SEL_CTRL = 1'b0;
  localparam logic FSP_SEL_KEY = 1'b1;

  // flash_op_control field positions
  localparam int FSP_GO_BIT = 15;
  localparam int FSP_EN_BIT = 14;
  localparam int FSP_FAULT_BIT = 13;
  localparam int FSP_ERASE_BIT = 6;
  localparam int FSP_OP_MSB = 3;
  localparam int FSP_OP_LSB = 0;
  localparam logic [15:0] FSP_CTRL_RESET = 16'h0000;

  // byte-enable lanes of the register port
  localparam int FSP_LANE_LO = 0;
  localparam int FSP_LANE_HI = 1;

  // unlock key values, low byte of flash_unlock_key
  localparam logic [7:0] FSP_KEY_FIRST = 8'h55;
  localparam logic [7:0] FSP_KEY_SECOND = 8'haa;

  // operation_select codes with the erase bit set
  localparam logic [3:0] FSP_OP_BULK_ERASE = 4'hf;
  localparam logic [3:0] FSP_OP_GSEG_ERASE = 4'hd;
  localparam logic [3:0] FSP_OP_SSEG_ERASE = 4'hc;
  localparam logic [3:0] FSP_OP_PAGE_ERASE = 4'h2;
  // operation_select codes with the erase bit clear
  localparam logic [3:0] FSP_OP_WORD_PROG = 4'h3;
  localparam logic [3:0] FSP_OP_ROW_PROG = 4'h1;

  // array geometry: 64 words a row, 8 rows a page, 2 address units a word
  localparam int FSP_ROW_WORDS = 64;
  localparam int FSP_IDX_W = 6;
  localparam int FSP_ROW_LOW_BITS = 7;
  localparam int FSP_PAGE_LOW_BITS = 10;
  localparam int FSP_ADDR_W = 24;
  localparam int FSP_WORD_W = 24;
  localparam logic [6:0] FSP_ROW_COUNT = 7'h40;
  localparam logic [6:0] FSP_ONE_WORD = 7'h01;

  // operation lengths in internal_fast_oscillator ticks
  localparam real FSP_FAST_OSC_MHZ = 7.37;
  localparam logic [15:0] FSP_ROW_WRITE_TICKS = 16'd11064;
  localparam logic [15:0] FSP_WORD_WRITE_TICKS = 16'd4096;
  localparam logic [15:0] FSP_PAGE_ERASE_TICKS = 16'd16384;
  localparam logic [15:0] FSP_BULK_ERASE_TICKS = 16'd32768;
  localparam logic [15:0] FSP_TICK_ONE = 16'h0001;

  typedef enum logic [1:0] {FSP_KEY_LOCKED, FSP_KEY_HALF, FSP_KEY_OPEN} fsp_key_t;
  typedef enum logic [1:0] {FSP_ST_IDLE, FSP_ST_STREAM, FSP_ST_TIMED} fsp_state_t;

endpackage

// ---- hdl/fsp_hold_buf.sv ----
// 64-word holding buffer with byte lanes and a registered read port
`timescale 1ns/100ps
`default_nettype none
module fsp_hold_buf
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] we,
  input wire logic [5:0] waddr,
  input wire logic [23:0] wdata,
  input wire logic [5:0] raddr,
  output logic [23:0] rdata
);

  // one lane of storage per program-word byte; each lane owns its array so
  // no storage word is written from two processes; no reset on the contents
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : lane
      logic [7:0] mem [0:63];
      logic [7:0] q_r;
      always_ff @(posedge clk)
      begin
        if (we[g])
          mem[waddr] <= wdata[g*8 +: 8];
      end
      // read data always from a flop, one cycle after the address
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          q_r <= 8'h00;
        else
          q_r <= mem[raddr];
      end
    end
  endgenerate

  // the three lane flops form the program word
  assign rdata = {lane[2].q_r, lane[1].q_r, lane[0].q_r};

endmodule
`default_nettype wire

// ---- hdl/fsp_flash_self_program_ctrl.sv ----
// self-programming controller: table access, holding buffer, unlock and timed flash operations
// Overview of operation
// - rows hold 64 words of 24 bits; a row program writes one row.
// - page erase clears eight consecutive rows, 512 words, in one operation.
// - pages align on 1536-byte, rows on 192-byte boundaries; low address bits ignored.
// - buffers are filled in order, all within one 64-word aligned group.
// - table write only updates the holding buffer and takes two cycles.
// - a single program word can be programmed as its own operation.
// - flash address is the 8-bit table page joined with the 16-bit address.
// - low-word table access reaches bits 15 to 0, word or byte mode.
// - high-word table access reaches bits 23 to 16 in word mode or at an even byte address; an odd byte reads zero.
// - the CPU stalls from operation start until it finishes.
// - duration is a fixed count of fast-oscillator ticks, 11064 for a row.
// - setting the go bit launches the operation; hardware clears it at completion.
// - keys 0x55 then 0xAA on consecutive writes must precede the go bit.
// - go bit is set-only from software; writing zero does nothing.
// - program-enable gates every program and erase; without it nothing changes.
// - erase codes: 1111 bulk, 1101 general segment, 1100 secure segment, 0010 page.
// - program codes: 0001 row from buffers, a separate code for one word.
// - erase select is bit 6, set for erases, clear for programming.
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_self_program_ctrl
#(
  parameter logic [15:0] ROW_TICKS = fsp_pkg::FSP_ROW_WRITE_TICKS,
  parameter logic [15:0] WORD_TICKS = fsp_pkg::FSP_WORD_WRITE_TICKS,
  parameter logic [15:0] PAGE_TICKS = fsp_pkg::FSP_PAGE_ERASE_TICKS,
  parameter logic [15:0] BULK_TICKS = fsp_pkg::FSP_BULK_ERASE_TICKS
)
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic REG_SEL,
  input wire logic [1:0] REG_BE,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic TBL_REQ,
  input wire logic TBL_WRITE,
  input wire logic TBL_HIGH,
  input wire logic TBL_BYTE,
  input wire logic [7:0] TABLE_PAGE_SELECT,
  input wire logic [15:0] TBL_EA,
  input wire logic [15:0] TBL_WDATA,
  output logic [15:0] TBL_RDATA,
  output logic TBL_ACK,
  output logic CPU_STALL,
  input wire logic FAST_OSC_TICK,
  output logic [23:0] ARR_RADDR,
  input wire logic [23:0] ARR_RDATA,
  output logic [23:0] ARR_ADDR,
  output logic [23:0] ARR_WDATA,
  output logic ARR_WE,
  output logic ARR_ERASE,
  output logic [3:0] ARR_ERASE_MODE
);

  fsp_pkg::fsp_state_t state_r;
  fsp_pkg::fsp_key_t key_r;
  logic go_r, en_r, fault_r, erase_r;
  logic [3:0] op_r;
  logic [15:0] rdata_r, tbl_rdata_r;
  logic tbl_ack_r;
  logic [23:0] buf_addr_r;
  logic buf_loaded_r, grp_bad_r;
  logic [5:0] stream_idx_r, wr_idx_r;
  logic [6:0] stream_left_r;
  logic stream_pend_r;
  logic [15:0] tick_cnt_r, target_r;
  logic erase_pulse_r;
  logic [23:0] buf_rdata;

  // register port decode
  wire idle = (state_r == fsp_pkg::FSP_ST_IDLE);
  wire wr_ctrl = REG_WE && (REG_SEL == fsp_pkg::FSP_SEL_CTRL) && idle;
  wire wr_key = REG_WE && (REG_SEL == fsp_pkg::FSP_SEL_KEY) && REG_BE[fsp_pkg::FSP_LANE_LO];
  wire wr_hi = wr_ctrl && REG_BE[fsp_pkg::FSP_LANE_HI];
  wire wr_lo = wr_ctrl && REG_BE[fsp_pkg::FSP_LANE_LO];
  wire [7:0] key_data = REG_WDATA[7:0];

  // fields as they stand after this write, so one write may set up and go
  wire en_w = wr_hi ? REG_WDATA[fsp_pkg::FSP_EN_BIT] : en_r;
  wire erase_w = wr_lo ? REG_WDATA[fsp_pkg::FSP_ERASE_BIT] : erase_r;
  wire [3:0] op_w = wr_lo ? REG_WDATA[fsp_pkg::FSP_OP_MSB:fsp_pkg::FSP_OP_LSB] : op_r;
  wire go_req = wr_hi && REG_WDATA[fsp_pkg::FSP_GO_BIT];
  wire op_is_page = erase_w && (op_w == fsp_pkg::FSP_OP_PAGE_ERASE);
  wire op_is_bulk = erase_w && (op_w == fsp_pkg::FSP_OP_BULK_ERASE);
  wire op_is_seg = erase_w && ((op_w == fsp_pkg::FSP_OP_GSEG_ERASE)
                   || (op_w == fsp_pkg::FSP_OP_SSEG_ERASE));
  wire op_is_row = !erase_w && (op_w == fsp_pkg::FSP_OP_ROW_PROG);
  wire op_is_word = !erase_w && (op_w == fsp_pkg::FSP_OP_WORD_PROG);
  wire op_valid = op_is_page || op_is_bulk || op_is_seg || op_is_row || op_is_word;
  wire seq_bad = (key_r != fsp_pkg::FSP_KEY_OPEN) || (op_is_row && grp_bad_r);
  wire launch = go_req && en_w && op_valid && !seq_bad;
  wire refuse = go_req && en_w && seq_bad;
  wire op_is_erase = op_is_page || op_is_bulk || op_is_seg;

  localparam logic FSP_CTRL_GO_RST = fsp_pkg::FSP_CTRL_RESET[fsp_pkg::FSP_GO_BIT];

  // control register fields; go sets only from software and clears only at the end
  wire op_done = (state_r == fsp_pkg::FSP_ST_TIMED) && FAST_OSC_TICK
                 && (tick_cnt_r == target_r - fsp_pkg::FSP_TICK_ONE);
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      go_r <= FSP_CTRL_GO_RST;
      en_r <= 1'b0;
      erase_r <= 1'b0;
      op_r <= 4'h0;
    end
    else
    begin
      if (launch)
        go_r <= 1'b1;
      else if (op_done)
        go_r <= 1'b0;
      if (wr_hi)
        en_r <= REG_WDATA[fsp_pkg::FSP_EN_BIT];
      if (wr_lo)
      begin
        erase_r <= REG_WDATA[fsp_pkg::FSP_ERASE_BIT];
        op_r <= REG_WDATA[fsp_pkg::FSP_OP_MSB:fsp_pkg::FSP_OP_LSB];
      end
    end
  end
  // fault flag: a refused start beats a software clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      fault_r <= 1'b0;
    else if (refuse)
      fault_r <= 1'b1;
    else if (launch)
      fault_r <= 1'b0;
    else if (wr_hi)
      fault_r <= REG_WDATA[fsp_pkg::FSP_FAULT_BIT];
  end

  // unlock tracker: any other register write in between discards a half key
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      key_r <= fsp_pkg::FSP_KEY_LOCKED;
    else if (wr_key && key_data == fsp_pkg::FSP_KEY_FIRST)
      key_r <= fsp_pkg::FSP_KEY_HALF;
    else if (wr_key && key_data == fsp_pkg::FSP_KEY_SECOND && key_r == fsp_pkg::FSP_KEY_HALF)
      key_r <= fsp_pkg::FSP_KEY_OPEN;
    else if (REG_WE)
      key_r <= fsp_pkg::FSP_KEY_LOCKED;
  end

  // register read data; the key register always reads zero
  wire [15:0] ctrl_view = {go_r, en_r, fault_r, 6'h00, erase_r, 2'h0, op_r};
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      rdata_r <= 16'h0000;
    else if (REG_RE)
      rdata_r <= (REG_SEL == fsp_pkg::FSP_SEL_KEY) ? 16'h0000 : ctrl_view;
  end

  // table access: address joins page and offset; taken only while idle
  wire [23:0] tbl_addr = {TABLE_PAGE_SELECT, TBL_EA};
  wire tbl_take = TBL_REQ && idle && !tbl_ack_r;
  wire tbl_wr = tbl_take && TBL_WRITE;
  wire tbl_rd = tbl_take && !TBL_WRITE;
  wire byte_hi = TBL_EA[0];
  wire [15:0] rd_low = TBL_BYTE ? {8'h00, (byte_hi ? ARR_RDATA[15:8] : ARR_RDATA[7:0])}
                       : ARR_RDATA[15:0];
  wire [15:0] rd_high = (TBL_BYTE && byte_hi) ? 16'h0000 : {8'h00, ARR_RDATA[23:16]};
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      tbl_ack_r <= 1'b0;
      tbl_rdata_r <= 16'h0000;
    end
    else
    begin
      tbl_ack_r <= tbl_take;
      if (tbl_rd)
        tbl_rdata_r <= TBL_HIGH ? rd_high : rd_low;
    end
  end

  // buffer lane enables: writes reach the holding buffer only, never the array
  wire [2:0] lanes_low = TBL_BYTE ? (byte_hi ? 3'h2 : 3'h1) : 3'h3;
  wire [2:0] lanes_high = (TBL_BYTE && byte_hi) ? 3'h0 : 3'h4;
  wire [2:0] buf_we = tbl_wr ? (TBL_HIGH ? lanes_high : lanes_low) : 3'h0;
  wire [23:0] buf_wdata = TBL_BYTE ? {3{TBL_WDATA[7:0]}} : {TBL_WDATA[7:0], TBL_WDATA};
  wire [5:0] buf_widx = tbl_addr[fsp_pkg::FSP_ROW_LOW_BITS-1:1];
  wire same_grp = (tbl_addr[23:fsp_pkg::FSP_ROW_LOW_BITS]
                   == buf_addr_r[23:fsp_pkg::FSP_ROW_LOW_BITS]);

  // remember the group being loaded and flag any write that strays outside it
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      buf_addr_r <= 24'h000000;
      buf_loaded_r <= 1'b0;
      grp_bad_r <= 1'b0;
    end
    else if (launch)
    begin
      buf_loaded_r <= 1'b0;
      grp_bad_r <= 1'b0;
    end
    else if (tbl_wr)
    begin
      buf_addr_r <= tbl_addr;
      buf_loaded_r <= 1'b1;
      if (buf_loaded_r && !same_grp)
        grp_bad_r <= 1'b1;
    end
  end

  // aligned bases; the low bits inside a row or page are dropped
  wire [23:0] row_base = {buf_addr_r[23:fsp_pkg::FSP_ROW_LOW_BITS], 7'h00};
  wire [23:0] page_base = {buf_addr_r[23:fsp_pkg::FSP_PAGE_LOW_BITS], 10'h000};
  wire [15:0] ticks_sel = op_is_row ? ROW_TICKS : op_is_word ? WORD_TICKS
                          : op_is_bulk ? BULK_TICKS : PAGE_TICKS;

  // sequencer: stream buffer words to the array, then wait out the tick count
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_r <= fsp_pkg::FSP_ST_IDLE;
      stream_idx_r <= 6'h00;
      stream_left_r <= 7'h00;
      stream_pend_r <= 1'b0;
      wr_idx_r <= 6'h00;
      tick_cnt_r <= 16'h0000;
      target_r <= 16'h0000;
      erase_pulse_r <= 1'b0;
    end
    else
    begin
      erase_pulse_r <= 1'b0;
      unique case (state_r)
        fsp_pkg::FSP_ST_IDLE:
        begin
          tick_cnt_r <= 16'h0000;
          if (launch)
          begin
            target_r <= ticks_sel;
            if (op_is_erase)
            begin
              erase_pulse_r <= 1'b1;
              state_r <= fsp_pkg::FSP_ST_TIMED;
            end
            else
            begin
              // word index from the last table write, matching the row base
              stream_idx_r <= op_is_row ? 6'h00 : buf_addr_r[fsp_pkg::FSP_ROW_LOW_BITS-1:1];
              stream_left_r <= op_is_row ? fsp_pkg::FSP_ROW_COUNT
                               : fsp_pkg::FSP_ONE_WORD;
              state_r <= fsp_pkg::FSP_ST_STREAM;
            end
          end
        end
        fsp_pkg::FSP_ST_STREAM:
        begin
          stream_pend_r <= (stream_left_r != 7'h00);
          wr_idx_r <= stream_idx_r;
          if (stream_left_r != 7'h00)
          begin
            stream_idx_r <= stream_idx_r + 6'h01;
            stream_left_r <= stream_left_r - 7'h01;
          end
          else if (stream_pend_r)
            state_r <= fsp_pkg::FSP_ST_TIMED;
        end
        fsp_pkg::FSP_ST_TIMED:
        begin
          stream_pend_r <= 1'b0;
          if (op_done)
            state_r <= fsp_pkg::FSP_ST_IDLE;
          else if (FAST_OSC_TICK)
            tick_cnt_r <= tick_cnt_r + fsp_pkg::FSP_TICK_ONE;
        end
      endcase
    end
  end

  fsp_hold_buf u_buf
  (
    .clk(CORE_CLK),
    .nrst(NRST),
    .we(buf_we),
    .waddr(buf_widx),
    .wdata(buf_wdata),
    .raddr(stream_idx_r),
    .rdata(buf_rdata)
  );

  // outputs; the stall holds from launch to completion
  assign CPU_STALL = !idle;
  assign REG_RDATA = rdata_r;
  assign TBL_RDATA = tbl_rdata_r;
  assign TBL_ACK = tbl_ack_r;
  assign ARR_RADDR = tbl_addr;
  assign ARR_WE = stream_pend_r && (state_r == fsp_pkg::FSP_ST_STREAM);
  assign ARR_WDATA = buf_rdata;
  assign ARR_ADDR = ARR_ERASE ? ((op_r == fsp_pkg::FSP_OP_PAGE_ERASE) ? page_base : row_base)
                    : (row_base | {17'h00000, wr_idx_r, 1'b0});
  assign ARR_ERASE = erase_pulse_r;
  assign ARR_ERASE_MODE = op_r;

  // checks, all on the core clock
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  logic [6:0] we_cnt_r;
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      we_cnt_r <= 7'h00;
    else if (launch)
      we_cnt_r <= 7'h00;
    else if (ARR_WE)
      we_cnt_r <= we_cnt_r + 7'h01;
  end

  sequence s_row_end;
    $fell(go_r) && !erase_r && (op_r == fsp_pkg::FSP_OP_ROW_PROG);
  endsequence

  a_tbl_two_cycle: assert property (tbl_take |=> TBL_ACK ##1 !TBL_ACK)
    else $error("table access not answered on the second cycle");
  a_stall_while_go: assert property (go_r |-> CPU_STALL)
    else $error("cpu not stalled while operation runs");
  a_refuse_fault: assert property (refuse |=> fault_r && !go_r && !CPU_STALL)
    else $error("locked start not refused with fault");
  a_enable_gate: assert property (go_req && !en_w |=> !CPU_STALL [*2])
    else $error("operation started without program enable");
  a_row_count: assert property (s_row_end |-> we_cnt_r == fsp_pkg::FSP_ROW_COUNT)
    else $error("row program did not write 64 words");
  a_go_clear: assert property (op_done |=> !go_r && !CPU_STALL)
    else $error("go bit not cleared at completion");
  a_key_zero: assert property (REG_RE && REG_SEL == fsp_pkg::FSP_SEL_KEY |=> REG_RDATA == 16'h0000)
    else $error("key register read not zero");
  a_page_align: assert property (ARR_ERASE && op_r == fsp_pkg::FSP_OP_PAGE_ERASE
    |-> ARR_ADDR[9:0] == 10'h000)
    else $error("page erase address not aligned");
  a_phantom_zero: assert property (tbl_rd && TBL_HIGH |=> TBL_RDATA[15:8] == 8'h00)
    else $error("high table read phantom byte not zero");
  a_launch_key: assert property ($rose(go_r) |-> $past(key_r) == fsp_pkg::FSP_KEY_OPEN)
    else $error("operation started without unlock");

endmodule
`default_nettype wire

// ---- testbench/fsp_flash_model.sv ----
// behavioural program flash array and free-running fast oscillator tick source
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model
#(
  parameter int TICK_DIV = 3
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [23:0] arr_raddr,
  output logic [23:0] arr_rdata,
  input wire logic [23:0] arr_addr,
  input wire logic [23:0] arr_wdata,
  input wire logic arr_we,
  input wire logic arr_erase,
  input wire logic [3:0] arr_erase_mode,
  output logic fast_osc_tick
);
  // 2048 words cover four erase pages; higher address bits alias onto them
  logic [23:0] mem [0:2047];
  int div_r;

  // array reads are combinational
  assign arr_rdata = mem[arr_raddr[11:1]];

  // the array starts erased
  initial
  begin
    foreach (mem[i])
      mem[i] = 24'hffffff;
  end

  // tick runs free, unrelated to what the controller is doing
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_r <= 0;
      fast_osc_tick <= 1'b0;
    end
    else
    begin
      div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
      fast_osc_tick <= (div_r == TICK_DIV - 1);
    end
  end

  // programming only clears bits, so a stale word shows if an erase is skipped
  always @(posedge clk)
  begin
    if (arr_we)
      mem[arr_addr[11:1]] <= mem[arr_addr[11:1]] & arr_wdata;
    if (arr_erase)
    begin
      // a page is 512 words on a 1024-unit boundary; other erase codes clear all
      foreach (mem[i])
        if (arr_erase_mode != 4'h2 || i[10:9] == arr_addr[11:10])
          mem[i] <= 24'hffffff;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench: register and table tasks drive the controller against a flash model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int NT = 4;
  localparam logic [15:0] K1 = 16'h0055;
  localparam logic [15:0] K2 = 16'h00aa;
  logic CORE_CLK = 1'b0, NRST = 1'b0;
  logic REG_WE = 1'b0, REG_RE = 1'b0, REG_SEL = 1'b0;
  logic [1:0] REG_BE = 2'h0;
  logic [15:0] REG_WDATA = 16'h0000, TBL_EA = 16'h0000, TBL_WDATA = 16'h0000;
  logic TBL_REQ = 1'b0, TBL_WRITE = 1'b0, TBL_HIGH = 1'b0, TBL_BYTE = 1'b0;
  logic [15:0] REG_RDATA, TBL_RDATA, rd;
  logic TBL_ACK, CPU_STALL, FAST_OSC_TICK, ARR_WE, ARR_ERASE;
  logic [23:0] ARR_RADDR, ARR_RDATA, ARR_ADDR, ARR_WDATA, er_addr;
  logic [3:0] ARR_ERASE_MODE, er_mode;
  logic [3:0] ecode [4] = '{4'h2, 4'hd, 4'hc, 4'hf};
  int err_count = 0, checks = 0, cyc = 0, we_cnt = 0, tick_cnt = 0;

  fsp_flash_self_program_ctrl #(.ROW_TICKS(16'(NT)), .WORD_TICKS(16'(NT)),
    .PAGE_TICKS(16'(NT)), .BULK_TICKS(16'(NT))) dut (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_SEL(REG_SEL), .REG_BE(REG_BE),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TBL_REQ(TBL_REQ), .TBL_WRITE(TBL_WRITE),
    .TBL_HIGH(TBL_HIGH), .TBL_BYTE(TBL_BYTE), .TABLE_PAGE_SELECT(8'h01), .TBL_EA(TBL_EA),
    .TBL_WDATA(TBL_WDATA), .TBL_RDATA(TBL_RDATA), .TBL_ACK(TBL_ACK), .CPU_STALL(CPU_STALL),
    .FAST_OSC_TICK(FAST_OSC_TICK), .ARR_RADDR(ARR_RADDR), .ARR_RDATA(ARR_RDATA),
    .ARR_ADDR(ARR_ADDR), .ARR_WDATA(ARR_WDATA), .ARR_WE(ARR_WE), .ARR_ERASE(ARR_ERASE),
    .ARR_ERASE_MODE(ARR_ERASE_MODE));

  fsp_flash_model flash (.clk(CORE_CLK), .nrst(NRST), .arr_raddr(ARR_RADDR),
    .arr_rdata(ARR_RDATA), .arr_addr(ARR_ADDR), .arr_wdata(ARR_WDATA), .arr_we(ARR_WE),
    .arr_erase(ARR_ERASE), .arr_erase_mode(ARR_ERASE_MODE), .fast_osc_tick(FAST_OSC_TICK));

  // 125 MHz core clock
  initial
  begin
    forever #4 CORE_CLK = ~CORE_CLK;
  end

  task automatic give_verdict;
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // all inputs move 1 ns after the rising edge
  task automatic step;
    @(posedge CORE_CLK);
    #1;
  endtask

  task automatic reg_wr(input logic sel, input logic [1:0] be, input logic [15:0] d);
    step();
    REG_WE = 1'b1;
    REG_SEL = sel;
    REG_BE = be;
    REG_WDATA = d;
    step();
    REG_WE = 1'b0;
  endtask

  task automatic reg_rd(input logic sel, output logic [15:0] q);
    step();
    REG_RE = 1'b1;
    REG_SEL = sel;
    step();
    REG_RE = 1'b0;
    q = REG_RDATA;
  endtask

  // request is dropped in the ack cycle so it is not taken twice
  task automatic tbl(input logic w, input logic hi, input logic by, input logic [15:0] ea,
    input logic [15:0] wd, output logic [15:0] q);
    step();
    TBL_REQ = 1'b1;
    TBL_WRITE = w;
    TBL_HIGH = hi;
    TBL_BYTE = by;
    TBL_EA = ea;
    TBL_WDATA = wd;
    step();
    TBL_REQ = 1'b0;
    chk(TBL_ACK, 1'b1);
    q = TBL_RDATA;
  endtask

  task automatic launch(input logic [15:0] ctrl);
    reg_wr(1'b1, 2'h1, K1);
    reg_wr(1'b1, 2'h1, K2);
    reg_wr(1'b0, 2'h3, ctrl);
  endtask

  // bounded wait for the operation to finish
  task automatic wait_idle;
    int n;
    n = 0;
    while (CPU_STALL !== 1'b0 && n < 2000)
    begin
      step();
      n++;
    end
    chk(24'(n < 2000), 24'h1);
  endtask

  // event counters and the hang guard
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    if (ARR_WE === 1'b1)
      we_cnt <= we_cnt + 1;
    if (FAST_OSC_TICK === 1'b1 && CPU_STALL === 1'b1 && we_cnt == 64)
      tick_cnt <= tick_cnt + 1;
    if (ARR_ERASE === 1'b1)
    begin
      er_mode <= ARR_ERASE_MODE;
      er_addr <= ARR_ADDR;
    end
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  initial
  begin
    repeat (12) @(posedge CORE_CLK);
    #1;
    NRST = 1'b1;
    // reset values and the write-only key
    reg_rd(1'b0, rd); chk(rd, 16'h0000);
    reg_wr(1'b1, 2'h1, 16'h0012);
    reg_rd(1'b1, rd); chk(rd, 16'h0000);
    // enable clear: the go bit does nothing and raises no fault
    launch(16'h8001);
    chk(CPU_STALL, 1'b0);
    reg_rd(1'b0, rd); chk(rd, 16'h0001);
    // load one row; the array must stay erased until launch
    for (int i = 0; i < 64; i++)
    begin
      tbl(1'b1, 1'b0, 1'b0, 16'(128 + 2 * i), 16'(4096 + i), rd);
      tbl(1'b1, 1'b1, 1'b0, 16'(128 + 2 * i), 16'(160 + i), rd);
    end
    tbl(1'b0, 1'b0, 1'b0, 16'h00fe, 16'h0000, rd); chk(rd, 16'hffff);
    chk(ARR_RADDR, 24'h0100fe);
    we_cnt = 0;
    tick_cnt = 0;
    launch(16'hc001);
    chk(CPU_STALL, 1'b1);
    // a clearing write while busy must not drop the go bit
    reg_wr(1'b0, 2'h3, 16'h0000);
    reg_rd(1'b0, rd); chk(rd[15], 1'b1);
    wait_idle();
    chk(24'(we_cnt), 24'd64);
    chk(24'(tick_cnt >= NT && tick_cnt <= NT + 1), 24'h1);
    reg_rd(1'b0, rd); chk(rd, 16'h4001);
    for (int i = 0; i < 64; i += 63)
    begin
      tbl(1'b0, 1'b0, 1'b0, 16'(128 + 2 * i), 16'h0000, rd); chk(rd, 16'(4096 + i));
      tbl(1'b0, 1'b1, 1'b0, 16'(128 + 2 * i), 16'h0000, rd); chk(rd, 16'(160 + i));
    end
    // broken unlocks and a row split across two groups are refused with a fault
    for (int k = 0; k < 5; k++)
    begin
      we_cnt = 0;
      case (k)
        1:
        begin
          reg_wr(1'b1, 2'h1, K2);
          reg_wr(1'b1, 2'h1, K1);
        end
        2:
        begin
          reg_wr(1'b1, 2'h1, K1);
          reg_wr(1'b0, 2'h3, 16'h4001);
          reg_wr(1'b1, 2'h1, K2);
        end
        3:
        begin
          reg_wr(1'b1, 2'h2, K1);
          reg_wr(1'b1, 2'h1, K2);
        end
        4:
        begin
          tbl(1'b1, 1'b0, 1'b0, 16'h0080, 16'h0000, rd);
          tbl(1'b1, 1'b0, 1'b0, 16'h0100, 16'h0000, rd);
          reg_wr(1'b1, 2'h1, K1);
          reg_wr(1'b1, 2'h1, K2);
        end
        default:
          ;
      endcase
      reg_wr(1'b0, 2'h3, 16'hc001);
      chk(CPU_STALL, 1'b0);
      reg_rd(1'b0, rd); chk(rd, 16'h6001);
      chk(24'(we_cnt), 24'd0);
    end
    // one word with a byte-lane write; a good launch clears the fault
    tbl(1'b1, 1'b0, 1'b0, 16'h0200, 16'h1234, rd);
    tbl(1'b1, 1'b0, 1'b1, 16'h0201, 16'h0056, rd);
    tbl(1'b1, 1'b1, 1'b0, 16'h0200, 16'h009a, rd);
    we_cnt = 0;
    launch(16'hc003);
    wait_idle();
    chk(24'(we_cnt), 24'd1);
    reg_rd(1'b0, rd); chk(rd, 16'h4003);
    tbl(1'b0, 1'b0, 1'b0, 16'h0200, 16'h0000, rd); chk(rd, 16'h5634);
    tbl(1'b0, 1'b1, 1'b0, 16'h0200, 16'h0000, rd); chk(rd, 16'h009a);
    tbl(1'b0, 1'b0, 1'b1, 16'h0201, 16'h0000, rd); chk(rd, 16'h0056);
    tbl(1'b0, 1'b1, 1'b1, 16'h0201, 16'h0000, rd); chk(rd, 16'h0000);
    // page code with the erase bit clear is a no-op
    launch(16'hc002);
    chk(CPU_STALL, 1'b0);
    reg_rd(1'b0, rd); chk(rd, 16'h4002);
    // page erase first, then the remaining erase codes
    for (int k = 0; k < 4; k++)
    begin
      tbl(1'b1, 1'b0, 1'b0, 16'h0290, 16'h0000, rd);
      launch(16'hc040 | 16'(ecode[k]));
      chk(CPU_STALL, 1'b1);
      wait_idle();
      chk(er_mode, ecode[k]);
      if (k == 0)
      begin
        chk(er_addr, 24'h010000);
        tbl(1'b0, 1'b0, 1'b0, 16'h0080, 16'h0000, rd); chk(rd, 16'hffff);
        tbl(1'b0, 1'b1, 1'b0, 16'h0200, 16'h0000, rd); chk(rd, 16'h00ff);
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
